//--- frd_defines.svh
// constants for the sector read command sequencer
`ifndef FRD_DEFINES_SVH
`define FRD_DEFINES_SVH
// =============================================
// command byte fields
`define FRD_OPC_LOW5       5'h06
`define FRD_OPC_SKIP_BIT   5
`define FRD_OPC_DENS_BIT   6
`define FRD_OPC_MULTI_BIT  7
`define FRD_DH_SIDE_BIT    2
`define FRD_DH_SEEK_BIT    7
`define FRD_CMD_BYTES      4'h9
// =============================================
// status bit positions
`define FRD_S1_NO_ADDR_MARK 0
`define FRD_S1_NO_DATA      2
`define FRD_S1_OVERRUN      4
`define FRD_S1_CRC          5
`define FRD_S1_END_TRACK    7
`define FRD_S2_BAD_TRACK    1
`define FRD_S2_WRONG_TRACK  4
`define FRD_S2_DATA_CRC     5
`define FRD_S2_DELETED      6
`define FRD_BAD_TRACK_VAL   8'hFF
`define FRD_IC_NORMAL       2'h0
`define FRD_IC_ABNORMAL     2'h1
// =============================================
// timing
`define FRD_CLK_NS          25
`define FRD_UNIT_US_CYC     (1000 / `FRD_CLK_NS)
`define FRD_INDEX_LIMIT     2'h2
`endif

//--- frd_delay.sv
// one-shot delay counter in microseconds
`timescale 1ns/1ps
`include "frd_defines.svh"
module frd_delay #(
  parameter int W = 16
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_us,
  output logic              o_done
);
  logic [W+5:0] cnt_r;
  logic         run_r;
  // six spare bits hold the largest microsecond count times the cycles per microsecond
  wire  [W+5:0] load_val = (W+6)'(i_us) * (W+6)'(`FRD_UNIT_US_CYC);
  assign o_done = run_r && (cnt_r == '0);
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end
    else if (i_start)
    begin
      cnt_r <= load_val;
      run_r <= 1'b1;
    end
    else if (o_done)
      run_r <= 1'b0;
    else if (run_r)
      cnt_r <= cnt_r - 1'b1;
  end
endmodule : frd_delay

//--- frd_drive_model.sv
// behavioural drive and data separator feeding the sequencer
`timescale 1ns/1ps
module frd_drive_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_seek_req,
  output logic            o_seek_done,
  output logic            o_index,
  output logic            o_id_valid,
  output frd_pkg::frd_id_t o_id_found,
  output logic            o_no_mark,
  output logic            o_data_found,
  output logic            o_deleted,
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_byte,
  output logic            o_sector_end,
  output logic            o_crc_err
);
  import frd_pkg::*;
  initial
  begin
    {o_seek_done, o_index, o_id_valid, o_no_mark, o_data_found, o_deleted, o_rd_valid, o_sector_end, o_crc_err} = '0;
    o_id_found = 32'h0000_0000;
    o_rd_byte = 8'h00;
  end
  // head steps take a while; answer only once per request
  initial forever
  begin
    @(posedge i_ref_clk iff i_seek_req);
    repeat (20) @(posedge i_ref_clk);
    o_seek_done <= 1'b1;
    @(posedge i_ref_clk);
    o_seek_done <= 1'b0;
    @(posedge i_ref_clk);
  end
  task index_pulse;
    @(posedge i_ref_clk);
    o_index <= 1'b1;
    @(posedge i_ref_clk);
    o_index <= 1'b0;
  endtask : index_pulse
  task no_mark;
    @(posedge i_ref_clk);
    o_no_mark <= 1'b1;
    @(posedge i_ref_clk);
    o_no_mark <= 1'b0;
  endtask : no_mark
  // stale id is inverted so a late sample cannot look valid
  task send_id(input frd_id_t id);
    @(posedge i_ref_clk);
    o_id_valid <= 1'b1;
    o_id_found <= id;
    @(posedge i_ref_clk);
    o_id_valid <= 1'b0;
    o_id_found <= ~id;
    repeat (4) @(posedge i_ref_clk);
  endtask : send_id
  task sector(input int n, input logic del, input logic crc, input logic [7:0] base, input int gap);
    @(posedge i_ref_clk);
    o_data_found <= 1'b1;
    o_deleted <= del;
    @(posedge i_ref_clk);
    o_data_found <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      repeat (gap) @(posedge i_ref_clk);
      o_rd_valid <= 1'b1;
      o_rd_byte <= base + 8'(i);
      @(posedge i_ref_clk);
      o_rd_valid <= 1'b0;
      o_rd_byte <= ~(base + 8'(i));
    end
    repeat (3) @(posedge i_ref_clk);
    o_sector_end <= 1'b1;
    o_crc_err <= crc;
    @(posedge i_ref_clk);
    o_sector_end <= 1'b0;
    o_crc_err <= 1'b0;
    o_deleted <= 1'b0;
  endtask : sector
endmodule : frd_drive_model

//--- frd_id_cmp.sv
// address field comparator
`timescale 1ns/1ps
`include "frd_defines.svh"
module frd_id_cmp (
  frd_id_if.cmp id
);
  import frd_pkg::*;
  assign id.trk_diff   = id.found.track != id.want.track;
  assign id.trk_bad    = id.found.track == `FRD_BAD_TRACK_VAL;
  assign id.other_diff = (id.found.head != id.want.head) || (id.found.sector != id.want.sector)
                         || (id.found.size != id.want.size);
  assign id.match      = !id.trk_diff && !id.other_diff;
endmodule : frd_id_cmp

//--- frd_id_if.sv
// interface carrying an address field to the id comparator
`timescale 1ns/1ps
interface frd_id_if;
  import frd_pkg::*;
  frd_id_t want;
  frd_id_t found;
  logic    match;
  logic    trk_diff;
  logic    trk_bad;
  logic    other_diff;
  modport cmp (input want, input found, output match, output trk_diff, output trk_bad, output other_diff);
  modport seq (output want, output found, input match, input trk_diff, input trk_bad, input other_diff);
endinterface : frd_id_if

//--- frd_pkg.sv
// types for the sector read command sequencer
package frd_pkg;
  typedef enum logic [3:0] {
    FRD_IDLE,
    FRD_COLLECT,
    FRD_PREDELAY,
    FRD_SEEK,
    FRD_SETTLE,
    FRD_SEARCH,
    FRD_DATA_WAIT,
    FRD_TRANSFER,
    FRD_RESULT
  } frd_state_t;
  typedef struct packed {
    logic [7:0] track;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } frd_id_t;
endpackage : frd_pkg

//--- frd_read_data.sv
// sector read command sequencer
// =============================================
// Summary of operation
// - host writes nine command bytes in order
// - wait drive pre-processing delay before search
// - opcode bit5 skips deleted-mark sectors
// - opcode bit6 picks single or double density
// - opcode bit7 continues onto side one
// - low two bits select logical drive
// - bit2 drives side select output
// - bit7 requests implied seek, soft reset clears
// - implied seek then head settle wait
// - compare each address field until match
// - last sector number bounds multi-sector read
// - eighth byte gives inter-sector gap
// - data goes by dma or programmed transfer
// - host fifo write aborts search
// - two index pulses without id end search
// - track mismatch sets wrong or bad track
// - head sector size mismatch sets missing data
// - no address mark sets missing mark bit
// - deleted mark skipped or read then stop
// - stop on count, end, overrun, crc
// - interrupt marks start of result phase
`timescale 1ns/1ps
`include "frd_defines.svh"
module frd_read_data #(
  parameter int DLY_W = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_soft_rst,
  input  wire logic             i_cmd_wr,
  input  wire logic [7:0]       i_cmd_byte,
  input  wire logic [DLY_W-1:0] i_predelay_us,
  input  wire logic [DLY_W-1:0] i_settle_us,
  input  wire logic             i_dma_mode,
  input  wire logic [7:0]       i_cur_track,
  output logic                  o_seek_req,
  input  wire logic             i_seek_done,
  input  wire logic             i_index,
  input  wire logic             i_id_valid,
  input  wire frd_pkg::frd_id_t i_id_found,
  input  wire logic             i_no_addr_mark,
  input  wire logic             i_data_found,
  input  wire logic             i_data_deleted,
  input  wire logic             i_rd_valid,
  input  wire logic [7:0]       i_rd_byte,
  input  wire logic             i_sector_end,
  input  wire logic             i_data_crc_err,
  input  wire logic             i_xfer_ack,
  input  wire logic             i_transfer_end_count,
  output logic                  o_dma_req,
  output logic                  o_pio_req,
  output logic [7:0]            o_xfer_byte,
  output logic [1:0]            o_drive_sel,
  output logic                  o_side_select_output,
  output logic                  o_double_density_encoding,
  output logic [7:0]            o_gap_len,
  output logic                  o_sep_run,
  output logic                  o_busy,
  output logic                  o_irq,
  output logic [7:0]            o_result_status_zero,
  output logic [7:0]            o_result_status_one,
  output logic [7:0]            o_result_status_two,
  output frd_pkg::frd_id_t      o_result_id
);
  import frd_pkg::*;
  // =============================================
  // command capture
  frd_state_t state_r;
  frd_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [7:0] opc_r;
  logic [7:0] dh_r;
  frd_id_t    want_r;
  logic [7:0] eot_r;
  logic [7:0] gap_r;
  logic [1:0] idx_r;
  logic       pend_r;
  logic [7:0] s0_r;
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic       stop_after_r;
  logic       seek_r;
  logic       irq_r;
  logic [7:0] byte_r;
  logic       dreq_r;
  logic       preq_r;
  wire multi_side_continue     = opc_r[`FRD_OPC_MULTI_BIT];
  wire deleted_sector_skip     = opc_r[`FRD_OPC_SKIP_BIT];
  wire implied_seek_enable     = dh_r[`FRD_DH_SEEK_BIT];
  wire side_select_bit         = dh_r[`FRD_DH_SIDE_BIT];
  wire last_byte               = i_cmd_wr && (cnt_r == `FRD_CMD_BYTES - 4'h1);
  wire opc_ok                  = i_cmd_byte[4:0] == `FRD_OPC_LOW5;
  wire at_last_sector          = want_r.sector == eot_r;
  wire can_flip                = multi_side_continue && !side_select_bit;
  wire need_seek               = implied_seek_enable && (i_cur_track != want_r.track);
  wire pre_done;
  wire settle_done;
  // =============================================
  // sub-blocks
  frd_id_if idb ();
  assign idb.want  = want_r;
  assign idb.found = i_id_found;
  frd_id_cmp u_cmp (
    .id (idb.cmp)
  );
  frd_delay #(.W(DLY_W)) u_pre (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_start   (last_byte && (state_r == FRD_COLLECT)),
    .i_us      (i_predelay_us),
    .o_done    (pre_done)
  );
  frd_delay #(.W(DLY_W)) u_settle (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_start   ((state_r == FRD_SEEK) && i_seek_done),
    .i_us      (i_settle_us),
    .o_done    (settle_done)
  );
  // =============================================
  // sequencing
  wire idx_limit   = i_index && (idx_r == `FRD_INDEX_LIMIT - 2'h1);
  wire host_abort  = i_cmd_wr && (state_r == FRD_SEARCH);
  wire id_hit      = i_id_valid && idb.match;
  wire sect_done   = (state_r == FRD_TRANSFER) && i_sector_end && !pend_r;
  wire end_of_run  = sect_done && (at_last_sector && !can_flip);
  wire any_stop    = sect_done && (i_transfer_end_count || i_data_crc_err || stop_after_r || end_of_run);
  wire overrun     = (state_r == FRD_TRANSFER) && i_rd_valid && pend_r;
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FRD_IDLE:      if (i_cmd_wr && opc_ok) state_nxt = FRD_COLLECT;
      FRD_COLLECT:   if (last_byte) state_nxt = FRD_PREDELAY;
      FRD_PREDELAY:  if (pre_done) state_nxt = need_seek ? FRD_SEEK : FRD_SEARCH;
      FRD_SEEK:      if (i_seek_done) state_nxt = FRD_SETTLE;
      FRD_SETTLE:    if (settle_done) state_nxt = FRD_SEARCH;
      FRD_SEARCH:
      begin
        if (host_abort || idx_limit || i_no_addr_mark) state_nxt = FRD_RESULT;
        else if (id_hit) state_nxt = FRD_DATA_WAIT;
      end
      FRD_DATA_WAIT:
      begin
        if (i_no_addr_mark) state_nxt = FRD_RESULT;
        else if (i_data_found && i_data_deleted && deleted_sector_skip) state_nxt = FRD_SEARCH;
        else if (i_data_found) state_nxt = FRD_TRANSFER;
      end
      FRD_TRANSFER:
      begin
        if (overrun || any_stop) state_nxt = FRD_RESULT;
        else if (sect_done) state_nxt = FRD_SEARCH;
      end
      FRD_RESULT:    if (i_cmd_wr) state_nxt = FRD_IDLE;
      default:       state_nxt = FRD_IDLE;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_r <= FRD_IDLE;
    else if (i_soft_rst)
      state_r <= FRD_IDLE;
    else
      state_r <= state_nxt;
  end
  // =============================================
  // command bytes; the ninth is ignored on purpose
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r  <= 4'h0;
      opc_r  <= 8'h00;
      dh_r   <= 8'h00;
      want_r <= '0;
      eot_r  <= 8'h00;
      gap_r  <= 8'h00;
    end
    else if (i_soft_rst)
    begin
      cnt_r <= 4'h0;
      dh_r  <= 8'h00;
    end
    else if (i_cmd_wr && (state_r == FRD_IDLE) && opc_ok)
    begin
      opc_r <= i_cmd_byte;
      cnt_r <= 4'h1;
    end
    else if (i_cmd_wr && (state_r == FRD_COLLECT))
    begin
      cnt_r <= last_byte ? 4'h0 : cnt_r + 4'h1;
      case (cnt_r)
        4'h1: dh_r <= i_cmd_byte;
        4'h2: want_r.track <= i_cmd_byte;
        4'h3: want_r.head <= i_cmd_byte;
        4'h4: want_r.sector <= i_cmd_byte;
        4'h5: want_r.size <= i_cmd_byte;
        4'h6: eot_r <= i_cmd_byte;
        4'h7: gap_r <= i_cmd_byte;
        default: ;
      endcase
    end
    else if (sect_done && !any_stop)
    begin
      if (at_last_sector && can_flip)
      begin
        dh_r[`FRD_DH_SIDE_BIT] <= 1'b1;
        want_r.head            <= 8'h01;
        want_r.sector          <= 8'h01;
      end
      else
        want_r.sector <= want_r.sector + 8'h01;
    end
  end
  // =============================================
  // index count, status and result
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      idx_r <= 2'h0;
    else if (state_r != FRD_SEARCH)
      idx_r <= 2'h0;
    else if (i_index)
      idx_r <= idx_r + 2'h1;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s0_r         <= 8'h00;
      s1_r         <= 8'h00;
      s2_r         <= 8'h00;
      stop_after_r <= 1'b0;
      irq_r        <= 1'b0;
    end
    // soft reset must not leave a stale interrupt standing in idle
    else if (i_soft_rst)
      irq_r <= 1'b0;
    else if (state_r == FRD_PREDELAY)
    begin
      s0_r         <= 8'h00;
      s1_r         <= 8'h00;
      s2_r         <= 8'h00;
      stop_after_r <= 1'b0;
      irq_r        <= 1'b0;
    end
    else
    begin
      if (i_id_valid && (state_r == FRD_SEARCH) && !idb.match)
      begin
        if (idb.trk_diff && idb.trk_bad)
          s2_r[`FRD_S2_BAD_TRACK] <= 1'b1;
        else if (idb.trk_diff)
          s2_r[`FRD_S2_WRONG_TRACK] <= 1'b1;
        if (idb.other_diff)
          s1_r[`FRD_S1_NO_DATA] <= 1'b1;
      end
      if (i_no_addr_mark && ((state_r == FRD_SEARCH) || (state_r == FRD_DATA_WAIT)))
        s1_r[`FRD_S1_NO_ADDR_MARK] <= 1'b1;
      if ((state_r == FRD_DATA_WAIT) && i_data_found && i_data_deleted)
      begin
        s2_r[`FRD_S2_DELETED] <= 1'b1;
        stop_after_r          <= !deleted_sector_skip;
      end
      if (overrun)
        s1_r[`FRD_S1_OVERRUN] <= 1'b1;
      if (sect_done && i_data_crc_err)
      begin
        s1_r[`FRD_S1_CRC]     <= 1'b1;
        s2_r[`FRD_S2_DATA_CRC] <= 1'b1;
      end
      if (end_of_run && !i_transfer_end_count)
        s1_r[`FRD_S1_END_TRACK] <= 1'b1;
      if (state_nxt == FRD_RESULT && state_r != FRD_RESULT)
      begin
        irq_r <= 1'b1;
        s0_r  <= {(sect_done && i_transfer_end_count && !i_data_crc_err) ? `FRD_IC_NORMAL : `FRD_IC_ABNORMAL,
                  3'h0, side_select_bit, dh_r[1:0]};
      end
      else if (state_r == FRD_RESULT && i_cmd_wr)
        irq_r <= 1'b0;
    end
  end
  // =============================================
  // byte hand-off to the host; one byte of holding, later bytes overrun
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pend_r <= 1'b0;
      byte_r <= 8'h00;
      dreq_r <= 1'b0;
      preq_r <= 1'b0;
      seek_r <= 1'b0;
    end
    else
    begin
      seek_r <= !i_soft_rst && (state_nxt == FRD_SEEK);
      if (i_soft_rst || (state_r != FRD_TRANSFER))
      begin
        pend_r <= 1'b0;
        dreq_r <= 1'b0;
        preq_r <= 1'b0;
      end
      else if (i_rd_valid && !pend_r)
      begin
        pend_r <= 1'b1;
        byte_r <= i_rd_byte;
        dreq_r <= i_dma_mode;
        preq_r <= !i_dma_mode;
      end
      else if (i_xfer_ack)
      begin
        pend_r <= 1'b0;
        dreq_r <= 1'b0;
        preq_r <= 1'b0;
      end
    end
  end
  // =============================================
  // outputs
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_drive_sel               <= 2'h0;
      o_side_select_output      <= 1'b0;
      o_double_density_encoding <= 1'b0;
      o_gap_len                 <= 8'h00;
      o_sep_run                 <= 1'b0;
      o_busy                    <= 1'b0;
    end
    else
    begin
      o_drive_sel               <= dh_r[1:0];
      o_side_select_output      <= side_select_bit;
      o_double_density_encoding <= opc_r[`FRD_OPC_DENS_BIT];
      o_gap_len                 <= gap_r;
      o_sep_run                 <= (state_r == FRD_SEARCH) || (state_r == FRD_DATA_WAIT)
                                   || (state_r == FRD_TRANSFER);
      o_busy                    <= state_r != FRD_IDLE;
    end
  end
  assign o_seek_req           = seek_r;
  assign o_dma_req            = dreq_r;
  assign o_pio_req            = preq_r;
  assign o_xfer_byte          = byte_r;
  assign o_irq                = irq_r;
  assign o_result_status_zero = s0_r;
  assign o_result_status_one  = s1_r;
  assign o_result_status_two  = s2_r;
  assign o_result_id          = want_r;
endmodule : frd_read_data

//--- frd_read_data_sva.sv
// assertion checker for the sector read sequencer
`timescale 1ns/1ps
module frd_read_data_sva (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_b,
  input wire logic       i_soft_rst,
  input wire logic       i_cmd_wr,
  input wire logic       i_dma_mode,
  input wire logic       i_seek_done,
  input wire logic       i_rd_valid,
  input wire logic       i_sector_end,
  input wire logic       i_xfer_ack,
  input wire logic       o_seek_req,
  input wire logic       o_dma_req,
  input wire logic       o_pio_req,
  input wire logic       o_sep_run,
  input wire logic       o_irq,
  input wire logic [7:0] o_result_status_one,
  input wire logic [7:0] o_result_status_two
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // =============================================
  // execution phase
  a_seek_end_cause: assert property ($fell(o_seek_req) |-> $past(i_seek_done) || $past(i_soft_rst))
    else $error("seek ended without completion");
  a_search_after_seek: assert property ($rose(o_sep_run) |-> !o_seek_req)
    else $error("search started during seek");
  a_dma_path: assert property ($rose(o_dma_req) |-> $past(i_dma_mode) && $past(i_rd_valid))
    else $error("dma request without byte or mode");
  a_pio_path: assert property ($rose(o_pio_req) |-> !$past(i_dma_mode) && $past(i_rd_valid))
    else $error("programmed request without byte or mode");
  a_one_path: assert property (!(o_dma_req && o_pio_req))
    else $error("both transfer requests high");
  a_req_holds: assert property (o_dma_req && !(i_xfer_ack || i_rd_valid || i_sector_end || i_soft_rst || i_cmd_wr)
    |=> o_dma_req)
    else $error("dma request dropped unserved");
  // =============================================
  // result phase
  a_irq_stands: assert property (o_irq && !i_cmd_wr && !i_soft_rst |=> o_irq && $stable(o_result_status_one))
    else $error("result phase did not hold");
  a_irq_clears: assert property (o_irq && i_cmd_wr |=> !o_irq)
    else $error("result phase not left on host write");
  a_track_excl: assert property (o_irq |-> !(o_result_status_two[1] && o_result_status_two[4]))
    else $error("wrong and bad track both set");
  cover property ($rose(o_irq) && o_result_status_one[7]);
  cover property ($fell(o_seek_req));
  cover property ($rose(o_pio_req));
  cover property ($rose(o_dma_req));
endmodule : frd_read_data_sva

bind frd_read_data frd_read_data_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_soft_rst(i_soft_rst),
  .i_cmd_wr(i_cmd_wr), .i_dma_mode(i_dma_mode), .i_seek_done(i_seek_done), .i_rd_valid(i_rd_valid),
  .i_sector_end(i_sector_end), .i_xfer_ack(i_xfer_ack), .o_seek_req(o_seek_req), .o_dma_req(o_dma_req),
  .o_pio_req(o_pio_req), .o_sep_run(o_sep_run), .o_irq(o_irq), .o_result_status_one(o_result_status_one),
  .o_result_status_two(o_result_status_two));

//--- testbench.sv
// self-checking bench for the sector read sequencer
`timescale 1ns/1ps
module testbench;
  import frd_pkg::*;
  logic clk, rst_b, soft_rst, cmd_wr, dma_mode, ack, tc, ack_en, seek_req, seek_done, index, id_valid;
  logic no_mark, data_found, deleted, rd_valid, sector_end, crc_err, dma_req, pio_req, side, dens, sep_run;
  logic busy, irq;
  logic [7:0] cmd_byte, cur_track, rd_byte, xbyte, gap, s0, s1, s2;
  logic [15:0] pre_us, set_us;
  logic [1:0] drive_sel;
  frd_id_t id_found, res_id;
  logic [7:0] got_q[$];
  int mismatches, cmp_count;
  logic [31:0] bad_id[3] = '{32'h0501_0102, 32'hFF01_0102, 32'h0301_0302};
  logic [15:0] mask[4] = '{16'h0010, 16'h0002, 16'h0400, 16'h0100};
  frd_read_data DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_soft_rst(soft_rst), .i_cmd_wr(cmd_wr),
    .i_cmd_byte(cmd_byte), .i_predelay_us(pre_us), .i_settle_us(set_us), .i_dma_mode(dma_mode),
    .i_cur_track(cur_track), .o_seek_req(seek_req), .i_seek_done(seek_done), .i_index(index),
    .i_id_valid(id_valid), .i_id_found(id_found), .i_no_addr_mark(no_mark), .i_data_found(data_found),
    .i_data_deleted(deleted), .i_rd_valid(rd_valid), .i_rd_byte(rd_byte), .i_sector_end(sector_end),
    .i_data_crc_err(crc_err), .i_xfer_ack(ack), .i_transfer_end_count(tc), .o_dma_req(dma_req),
    .o_pio_req(pio_req), .o_xfer_byte(xbyte), .o_drive_sel(drive_sel), .o_side_select_output(side),
    .o_double_density_encoding(dens), .o_gap_len(gap), .o_sep_run(sep_run), .o_busy(busy), .o_irq(irq),
    .o_result_status_zero(s0), .o_result_status_one(s1), .o_result_status_two(s2), .o_result_id(res_id));
  frd_drive_model md (.i_ref_clk(clk), .i_seek_req(seek_req), .o_seek_done(seek_done), .o_index(index),
    .o_id_valid(id_valid), .o_id_found(id_found), .o_no_mark(no_mark), .o_data_found(data_found),
    .o_deleted(deleted), .o_rd_valid(rd_valid), .o_rd_byte(rd_byte), .o_sector_end(sector_end),
    .o_crc_err(crc_err));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // host side takes each offered byte one cycle later
  always @(posedge clk)
    if (ack_en && (dma_req || pio_req) && !ack)
    begin
      ack <= 1'b1;
      got_q.push_back(xbyte);
    end
    else
      ack <= 1'b0;
  // =============================================
  // access tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr1(input logic [7:0] b);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_byte <= b;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask : wr1
  task cmd(input logic [7:0] op, input logic [7:0] dh, input logic [7:0] sc, input logic [7:0] last_sector_number);
    logic [7:0] b[9];
    b = '{op, dh, 8'h03, {7'h00, dh[2]}, sc, 8'h02, last_sector_number, 8'h1B, 8'hFF};
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      cmd_wr <= 1'b1;
      cmd_byte <= b[i];
    end
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask : cmd
  task wait_run;
    for (int i = 0; i < 400 && sep_run !== 1'b1; i++) @(negedge clk);
  endtask : wait_run
  task wait_irq;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge clk);
    chk(irq, 1);
  endtask : wait_irq
  task fin;
    wr1(8'h00);
    repeat (2) @(negedge clk);
    chk(irq, 0);
    got_q.delete();
  endtask : fin
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial
  begin
    #750_000;
    mismatches++;
    summarize();
  end
  // =============================================
  // scenarios
  initial
  begin
    {rst_b, soft_rst, cmd_wr, tc} = '0;
    {dma_mode, ack_en} = 2'b11;
    cmd_byte = 8'h00;
    cur_track = 8'h00;
    pre_us = 16'h0001;
    set_us = 16'h0001;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({irq, busy, sep_run, dma_req}, 0);
    wr1(8'h47);
    repeat (3) @(negedge clk);
    chk(busy, 0);
    cmd(8'h46, 8'h05, 8'h01, 8'h01);
    wait_run;
    chk({drive_sel, side, dens, gap}, {2'h1, 1'b1, 1'b1, 8'h1B});
    md.send_id(32'h0501_0102);
    md.send_id(32'h0301_0102);
    md.sector(4, 0, 0, 8'hA0, 4);
    wait_irq;
    chk({s0[7:6], s1[7]}, 3'b011);
    chk(got_q.size(), 4);
    foreach (got_q[i]) chk(got_q[i], 8'hA0 + 8'(i));
    fin;
    dma_mode <= 1'b0;
    tc <= 1'b1;
    cmd(8'h06, 8'h00, 8'h01, 8'h02);
    wait_run;
    md.send_id(32'h0300_0102);
    md.sector(2, 0, 0, 8'h50, 4);
    wait_irq;
    chk({s0[7:6], side, dens, 8'(got_q.size())}, {4'h0, 8'h02});
    tc <= 1'b0;
    fin;
    cmd(8'h46, 8'h05, 8'h01, 8'h02);
    wait_run;
    md.send_id(32'h0301_0102);
    md.sector(1, 1, 0, 8'h10, 4);
    wait_irq;
    chk(s2[6], 1);
    fin;
    cmd(8'h66, 8'h05, 8'h01, 8'h02);
    wait_run;
    md.send_id(32'h0301_0102);
    md.sector(2, 1, 0, 8'h20, 4);
    wr1(8'h00);
    wait_irq;
    chk(got_q.size(), 0);
    fin;
    for (int k = 0; k < 4; k++)
    begin
      cmd(8'h46, 8'h05, 8'h01, 8'h01);
      wait_run;
      if (k < 3)
      begin
        md.send_id(bad_id[k]);
        md.index_pulse();
        md.send_id(bad_id[k]);
        md.index_pulse();
      end
      else
        md.no_mark();
      wait_irq;
      chk({s1, s2} & mask[k], mask[k]);
      fin;
    end
    ack_en <= 1'b0;
    cmd(8'h46, 8'h05, 8'h01, 8'h01);
    wait_run;
    md.send_id(32'h0301_0102);
    md.sector(2, 0, 0, 8'h30, 4);
    wait_irq;
    chk({s0[7:6], s1[4]}, 3'b011);
    ack_en <= 1'b1;
    fin;
    cmd(8'h46, 8'h05, 8'h01, 8'h01);
    wait_run;
    md.send_id(32'h0301_0102);
    md.sector(1, 0, 1, 8'h40, 4);
    wait_irq;
    chk({s1[5], s2[5]}, 2'b11);
    fin;
    cur_track <= 8'h03;
    cmd(8'hC6, 8'h81, 8'h01, 8'h01);
    wait_run;
    md.send_id(32'h0300_0102);
    md.sector(1, 0, 0, 8'h60, 4);
    md.send_id(32'h0301_0102);
    md.sector(1, 0, 0, 8'h70, 4);
    wait_irq;
    chk(res_id, 32'h0301_0102);
    chk({side, s1[7], 8'(got_q.size())}, {2'b11, 8'h02});
    cur_track <= 8'h00;
    pre_us <= 16'h0002;
    set_us <= 16'h0002;
    fin;
    cmd(8'h46, 8'h85, 8'h01, 8'h01);
    for (int i = 0; i < 400 && seek_req !== 1'b1; i++) @(negedge clk);
    chk(seek_req, 1);
    wait_run;
    chk(seek_req, 0);
    wr1(8'h00);
    wait_irq;
    fin;
    cmd(8'h46, 8'h05, 8'h01, 8'h01);
    wait_run;
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk({busy, sep_run, irq, drive_sel, side}, 0);
    summarize();
  end
endmodule : testbench
